// >>> bench/meter_link_message_handler_tb.sv
// Self-checking bench for the meter link message handler.
// Assumes a prescaler of ten cycles per second and a collector model on TX.
`timescale 1ns/1ps
`default_nettype none
module meter_link_message_handler_tb;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic T_MODE = 1'b0;
    logic [15:0] INTERVAL_SEC = 16'h0000;
    logic KEY_VALID = 1'b0;
    logic BIDIR = 1'b1;
    logic INSTALL_BTN = 1'b0;
    logic [7:0] ALARM_STATUS = 8'h5c;
    logic RX_VALID = 1'b0;
    mlmh_pkg::mlmh_rx_t RX = '0;
    logic TX_VALID, TX_READY, TIME_SET, TIME_ADJ, INSTALLING, hold_bad;
    logic SLOW = 1'b0;
    mlmh_pkg::mlmh_tx_t TX, last;
    int n_frames, n_sync, t_last;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    mlmh_handler #(.CYC_PER_SEC(10)) mlmh_handler_inst (.CLK(CLK), .SRST(SRST), .T_MODE(T_MODE),
        .INTERVAL_SEC(INTERVAL_SEC), .KEY_VALID(KEY_VALID), .BIDIR(BIDIR),
        .INSTALL_BTN(INSTALL_BTN), .ALARM_STATUS(ALARM_STATUS), .RX_VALID(RX_VALID), .RX(RX),
        .TX_VALID(TX_VALID), .TX(TX), .TX_READY(TX_READY), .TIME_SET(TIME_SET),
        .TIME_ADJ(TIME_ADJ), .INSTALLING(INSTALLING));
    mlmh_collector mlmh_collector_inst (.CLK(CLK), .SLOW(SLOW), .TX_VALID(TX_VALID), .TX(TX),
        .TX_READY(TX_READY), .LAST(last), .N_FRAMES(n_frames), .N_SYNC(n_sync),
        .T_LAST(t_last), .HOLD_BAD(hold_bad));

    // Clock of 10 ns and a ceiling on the run length.
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic send_rx(input logic [7:0] c, input logic [7:0] ci);
        @(negedge CLK);
        RX_VALID = 1'b1;
        RX = {c, ci};
        @(negedge CLK);
        RX_VALID = 1'b0;
    endtask : send_rx

    // Waits a bounded time for the next accepted frame.
    task automatic next_frame(output mlmh_pkg::mlmh_tx_t f);
        int n0;
        n0 = n_frames;
        repeat (200) begin
            @(negedge CLK);
            if (n_frames != n0) break;
        end
        chk("frame arrived", 40'h1, 40'(n_frames != n0));
        f = last;
    endtask : next_frame

    task automatic t_periodic;
        mlmh_pkg::mlmh_tx_t f, g;
        int t0;
        next_frame(f);
        t0 = t_last;
        for (int i = 0; i < 2; i++) begin
            next_frame(g);
            chk("periodic code", 40'(mlmh_pkg::C_SND_NR), 40'(g.c));
            chk("sync flag", 40'h1, 40'(g.sync));
            chk("access step", 40'(f.acc + 8'h01), 40'(g.acc));
            chk("interval", 40'd10, 40'(t_last - t0));
            chk("status byte", 40'h5c, 40'(g.status));
            f = g;
            t0 = t_last;
        end
        SLOW = 1'b1;
        INTERVAL_SEC = 16'h0002;
        next_frame(g);
        chk("held frame", 40'h0, 40'(hold_bad));
        chk("synced frames", 40'h1, 40'(n_sync >= 2));
        SLOW = 1'b0;
        INTERVAL_SEC = 16'hffff;
        repeat (40) @(negedge CLK);
        $display("test periodic done");
    endtask : t_periodic

    task automatic t_replies;
        logic [7:0] req [6] = '{8'h53, 8'h73, 8'h5a, 8'h7a, 8'h5b, 8'h7b};
        mlmh_pkg::mlmh_tx_t f;
        logic [7:0] e;
        for (int a = 0; a < 2; a++) begin
            ALARM_STATUS = a ? 8'h21 : 8'h00;
            for (int i = 0; i < 6; i++) begin
                send_rx(req[i], mlmh_pkg::CI_METER);
                next_frame(f);
                e = (i >= 4 || (i >= 2 && a)) ? mlmh_pkg::C_RSP_UD : mlmh_pkg::C_ACK;
                chk("reply code", 40'(e), 40'(f.c));
                chk("reply ci", 40'(mlmh_pkg::CI_METER), 40'(f.ci));
                chk("reply sync", 40'h0, 40'(f.sync));
                chk("reply status", 40'(ALARM_STATUS), 40'(f.status));
            end
        end
        $display("test replies done");
    endtask : t_replies

    task automatic t_time;
        mlmh_pkg::mlmh_tx_t f;
        for (int k = 0; k < 4; k++) begin
            @(negedge CLK);
            KEY_VALID = k[0];
            send_rx(mlmh_pkg::C_SND_UD_A, k[1] ? mlmh_pkg::CI_ADJ_TIME : mlmh_pkg::CI_SET_TIME);
            chk("time set", 40'(k[0] && !k[1]), 40'(TIME_SET));
            chk("time adj", 40'(k[0] && k[1]), 40'(TIME_ADJ));
            @(negedge CLK);
            chk("time pulse end", 40'h0, 40'({TIME_SET, TIME_ADJ}));
            next_frame(f);
            chk("time ack", 40'(mlmh_pkg::C_ACK), 40'(f.c));
        end
        $display("test time done");
    endtask : t_time

    task automatic t_unsupported;
        int n0;
        n0 = n_frames;
        send_rx(8'h44, mlmh_pkg::CI_METER);
        send_rx(8'h08, mlmh_pkg::CI_METER);
        @(negedge CLK);
        BIDIR = 1'b0;
        T_MODE = 1'b1;
        send_rx(mlmh_pkg::C_SND_UD_A, mlmh_pkg::CI_METER);
        repeat (30) @(negedge CLK);
        BIDIR = 1'b1;
        T_MODE = 1'b0;
        chk("no reply", 40'(n0), 40'(n_frames));
        $display("test unsupported done");
    endtask : t_unsupported

    task automatic t_install;
        mlmh_pkg::mlmh_tx_t f;
        int t0, w;
        for (int p = 0; p < 2; p++) begin
            @(negedge CLK);
            INSTALL_BTN = 1'b1;
            @(negedge CLK);
            INSTALL_BTN = 1'b0;
            chk("installing", 40'h1, 40'(INSTALLING));
            next_frame(f);
            t0 = t_last;
            chk("install code", 40'({mlmh_pkg::C_INST, 8'h00}), 40'({f.c, 7'h0, f.sync}));
            // The first gap depends on the prescaler phase; time the period on later frames.
            next_frame(f);
            t0 = t_last;
            next_frame(f);
            chk("install period", 40'd100, 40'(t_last - t0));
            if (p == 0) begin
                send_rx(mlmh_pkg::C_CNF_INST, mlmh_pkg::CI_METER);
                @(negedge CLK);
                chk("confirmed", 40'h0, 40'(INSTALLING));
            end
        end
        w = 0;
        while (INSTALLING === 1'b1 && w < 6200) begin
            @(negedge CLK);
            w++;
        end
        chk("install timeout", 40'h1, 40'(w >= 5780 && w <= 5830));
        $display("test install done");
    endtask : t_install

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // Reset, then each scenario in turn.
    initial begin
        repeat (16) @(negedge CLK);
        SRST = 1'b0;
        t_periodic();
        t_replies();
        t_time();
        t_unsupported();
        t_install();
        print_verdict();
    end
endmodule : meter_link_message_handler_tb
`default_nettype wire

// >>> bench/mlmh_collector.sv
// Behavioural data collector that takes the handler's outgoing frames.
// Assumes it shares the handler clock and sees its TX handshake directly.
`timescale 1ns/1ps
`default_nettype none
module mlmh_collector (
    input wire logic CLK,
    input wire logic SLOW,
    input wire logic TX_VALID,
    input wire mlmh_pkg::mlmh_tx_t TX,
    output logic TX_READY,
    output mlmh_pkg::mlmh_tx_t LAST,
    output int N_FRAMES,
    output int N_SYNC,
    output int T_LAST,
    output logic HOLD_BAD
);
    int cyc = 0;
    logic [1:0] gap = 2'h0;
    logic was_wait = 1'b0;
    mlmh_pkg::mlmh_tx_t held;

    initial begin
        TX_READY = 1'b0;
        LAST = '0;
        N_FRAMES = 0;
        N_SYNC = 0;
        T_LAST = 0;
        HOLD_BAD = 1'b0;
    end

    // Ready is given at once, or only one cycle in four when SLOW; a waiting frame must hold.
    // Outside SLOW the model listens all the time, as a collector does after install.
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        gap <= gap + 2'h1;
        TX_READY <= !SLOW || (gap == 2'h2);
        if (TX_VALID && was_wait && TX !== held) begin
            HOLD_BAD <= 1'b1;
        end
        was_wait <= TX_VALID && !TX_READY;
        held <= TX;
        if (TX_VALID && TX_READY) begin
            LAST <= TX;
            T_LAST <= cyc;
            N_FRAMES <= N_FRAMES + 1;
            // Synchronous frames are counted; two are needed before a prediction.
            if (TX.sync) begin
                N_SYNC <= N_SYNC + 1;
            end
        end
    end
endmodule : mlmh_collector
`default_nettype wire

// >>> core/mlmh_handler.sv
// Message-type handling of a wireless meter at the link layer.
// Assumes a framer that takes TX when TX_VALID and TX_READY are both high,
// and that presents each received header for one cycle on RX_VALID.
`timescale 1ns/1ps
`default_nettype none
module mlmh_handler #(
    parameter int unsigned CYC_PER_SEC = mlmh_pkg::CYC_PER_SEC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic T_MODE,
    input wire logic [15:0] INTERVAL_SEC,
    input wire logic KEY_VALID,
    input wire logic BIDIR,
    input wire logic INSTALL_BTN,
    input wire logic [7:0] ALARM_STATUS,
    input wire logic RX_VALID,
    input wire mlmh_pkg::mlmh_rx_t RX,
    output logic TX_VALID,
    output mlmh_pkg::mlmh_tx_t TX,
    input wire logic TX_READY,
    output logic TIME_SET,
    output logic TIME_ADJ,
    output logic INSTALLING
);
    mlmh_pkg::mlmh_state_t s;
    mlmh_pkg::mlmh_state_t next_s;
    logic sec_tick;
    logic [15:0] per_cap;
    logic [15:0] per_lim;
    logic [7:0] rx_c;

    mlmh_prescale #(
        .LIMIT(CYC_PER_SEC)
    ) u_sec (
        .CLK(CLK),
        .SRST(SRST),
        .TICK(sec_tick)
    );

    // Effective interval: at least one second and no more than the mode cap.
    always_comb begin
        per_cap = T_MODE ? mlmh_pkg::MAX_T_SEC : mlmh_pkg::MAX_S_SEC;
        if (INTERVAL_SEC == 16'h0000) begin
            per_lim = 16'h0001;
        end else if (INTERVAL_SEC > per_cap) begin
            per_lim = per_cap;
        end else begin
            per_lim = INTERVAL_SEC;
        end
    end

    assign rx_c = RX.c;

    // Next state: transmit scheduling first, so that events set later win.
    always_comb begin
        next_s = s;
        next_s.time_set = 1'b0;
        next_s.time_adj = 1'b0;
        // Frame launch and completion; replies beat installation beats periodic.
        unique case (s.st)
            mlmh_pkg::ST_IDLE: begin
                if (s.rep_pend || s.inst_pend || s.per_pend) begin
                    next_s.st = mlmh_pkg::ST_SEND;
                    next_s.tx.ci = mlmh_pkg::CI_METER;
                    next_s.tx.acc = s.acc;
                    next_s.acc = s.acc + 8'h01;
                    next_s.tx.status = ALARM_STATUS;
                    if (s.rep_pend) begin
                        next_s.tx.c = s.rep_c;
                        next_s.rep_pend = 1'b0;
                    end else if (s.inst_pend) begin
                        next_s.tx.c = mlmh_pkg::C_INST;
                        next_s.inst_pend = 1'b0;
                    end else begin
                        next_s.tx.c = mlmh_pkg::C_SND_NR;
                        next_s.per_pend = 1'b0;
                    end
                    next_s.tx.sync = (next_s.tx.c == mlmh_pkg::C_SND_NR) ||
                        (next_s.tx.c == mlmh_pkg::C_ACC_DMD) ||
                        (next_s.tx.c == mlmh_pkg::C_ACC_NR);
                end
            end
            mlmh_pkg::ST_SEND: begin
                if (TX_READY) begin
                    next_s.st = mlmh_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.st = mlmh_pkg::ST_IDLE;
            end
        endcase
        // Periodic interval timer in whole seconds.
        if (sec_tick) begin
            if (s.per_cnt >= per_lim - 16'h0001) begin
                next_s.per_cnt = 16'h0000;
                next_s.per_pend = 1'b1;
            end else begin
                next_s.per_cnt = s.per_cnt + 16'h0001;
            end
        end
        // Installation period and timeout while installing.
        if (s.installing && sec_tick) begin
            next_s.inst_per = s.inst_per + 16'h0001;
            next_s.inst_tmo = s.inst_tmo + 16'h0001;
            if (s.inst_per >= mlmh_pkg::INST_PERIOD_SEC - 16'h0001) begin
                next_s.inst_per = 16'h0000;
                next_s.inst_pend = 1'b1;
            end
            if (s.inst_tmo >= mlmh_pkg::INST_TIMEOUT_SEC - 16'h0001) begin
                next_s.installing = 1'b0;
                next_s.inst_pend = 1'b0;
            end
        end
        // Manual trigger starts installation with an immediate frame.
        if (INSTALL_BTN) begin
            next_s.installing = 1'b1;
            next_s.inst_pend = 1'b1;
            next_s.inst_per = 16'h0000;
            next_s.inst_tmo = 16'h0000;
        end
        // Received commands; a one-way meter ignores them all.
        if (RX_VALID && BIDIR) begin
            unique case (rx_c)
                mlmh_pkg::C_SND_UD_A, mlmh_pkg::C_SND_UD_B: begin
                    next_s.rep_pend = 1'b1;
                    next_s.rep_c = mlmh_pkg::C_ACK;
                    // Plain time data only; no encrypted time is decoded.
                    next_s.time_set = KEY_VALID && (RX.ci == mlmh_pkg::CI_SET_TIME);
                    next_s.time_adj = KEY_VALID && (RX.ci == mlmh_pkg::CI_ADJ_TIME);
                end
                mlmh_pkg::C_REQ1_A, mlmh_pkg::C_REQ1_B: begin
                    next_s.rep_pend = 1'b1;
                    // Data when an alarm is standing, a bare acknowledge otherwise.
                    next_s.rep_c = (ALARM_STATUS != 8'h00) ? mlmh_pkg::C_RSP_UD
                        : mlmh_pkg::C_ACK;
                end
                mlmh_pkg::C_REQ2_A, mlmh_pkg::C_REQ2_B: begin
                    next_s.rep_pend = 1'b1;
                    next_s.rep_c = mlmh_pkg::C_RSP_UD;
                end
                mlmh_pkg::C_CNF_INST: begin
                    next_s.installing = 1'b0;
                    next_s.inst_pend = 1'b0;
                end
                default: begin
                    next_s.rep_pend = next_s.rep_pend;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s <= '0;
            s.st <= mlmh_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state.
    assign TX_VALID = (s.st == mlmh_pkg::ST_SEND);
    assign TX = s.tx;
    assign TIME_SET = s.time_set;
    assign TIME_ADJ = s.time_adj;
    assign INSTALLING = s.installing;

    // Helper: access number of the previous frame.
    logic sent_once;
    logic [7:0] last_acc;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sent_once <= 1'b0;
            last_acc <= 8'h00;
        end else if (TX_VALID && TX_READY) begin
            sent_once <= 1'b1;
            last_acc <= TX.acc;
        end
    end

    a_sync_codes: assert property (@(posedge CLK) disable iff (SRST)
        TX_VALID && TX.sync |-> (TX.c == mlmh_pkg::C_SND_NR) ||
        (TX.c == mlmh_pkg::C_ACC_DMD) || (TX.c == mlmh_pkg::C_ACC_NR))
        else $error("Sync flag on a code that may not be synchronous.");
    a_periodic_sync: assert property (@(posedge CLK) disable iff (SRST)
        TX_VALID && TX.c == mlmh_pkg::C_SND_NR |-> TX.sync)
        else $error("Periodic frame without sync flag.");
    a_acc_step: assert property (@(posedge CLK) disable iff (SRST)
        $rose(TX_VALID) && sent_once |-> TX.acc == last_acc + 8'h01)
        else $error("Access number did not step by one.");
    a_interval_cap: assert property (@(posedge CLK) disable iff (SRST)
        per_lim <= (T_MODE ? 16'h0384 : 16'h1518) && per_lim != 16'h0000)
        else $error("Interval exceeds the mode limit.");
    a_snd_ack: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && BIDIR && (rx_c == 8'h53 || rx_c == 8'h73)
        |=> s.rep_pend && s.rep_c == 8'h00)
        else $error("Send-user-data not queued for acknowledge.");
    a_time_ack: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && BIDIR && rx_c == 8'h53 && RX.ci == 8'h6c && !KEY_VALID
        |=> s.rep_pend && !TIME_SET)
        else $error("Time command without key not acknowledged or applied.");
    a_time_key: assert property (@(posedge CLK) disable iff (SRST)
        TIME_SET || TIME_ADJ |-> $past(KEY_VALID))
        else $error("Time changed without a valid key.");
    a_req1_ans: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && BIDIR && (rx_c == 8'h5a || rx_c == 8'h7a)
        |=> s.rep_pend && (s.rep_c == 8'h00 || s.rep_c == 8'h08))
        else $error("Class-1 request got a wrong answer.");
    a_req2_rsp: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && BIDIR && (rx_c == 8'h5b || rx_c == 8'h7b)
        |=> s.rep_pend && s.rep_c == 8'h08)
        else $error("Class-2 request not answered with user data.");
    a_drop_unknown: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && (!BIDIR || !(rx_c inside {8'h53, 8'h73, 8'h5a, 8'h7a, 8'h5b, 8'h7b}))
        && !s.rep_pend |=> !s.rep_pend)
        else $error("Unsupported code produced a reply.");
    a_inst_stop: assert property (@(posedge CLK) disable iff (SRST)
        RX_VALID && BIDIR && rx_c == 8'h06 && !INSTALL_BTN |=> !INSTALLING && !s.inst_pend)
        else $error("Confirmation did not end installation.");
    a_status_byte: assert property (@(posedge CLK) disable iff (SRST)
        $rose(TX_VALID) |-> TX.status == $past(ALARM_STATUS))
        else $error("Status byte not taken at frame launch.");

    c_periodic: cover property (@(posedge CLK) TX_VALID && TX_READY && TX.c == 8'h44);
    c_reply: cover property (@(posedge CLK) TX_VALID && TX_READY && TX.c == 8'h08);
    c_install_cnf: cover property (@(posedge CLK) $fell(INSTALLING));
    c_time_set: cover property (@(posedge CLK) TIME_SET);

endmodule : mlmh_handler
`default_nettype wire

// >>> core/mlmh_pkg.sv
// Constants, codes and carrier types of the meter link message handler.
// Assumes a 100 MHz system clock and the link-layer framer outside.
package mlmh_pkg;

    // Clock period and one second, in ns; cycles per second derive from them.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ONE_SEC_NS = 1000000000;
    localparam int unsigned CYC_PER_SEC = ONE_SEC_NS / CLK_PERIOD_NS;

    // Longest periodic interval per radio mode, in minutes and in seconds.
    localparam logic [15:0] MAX_S_MIN = 16'h005a;
    localparam logic [15:0] MAX_T_MIN = 16'h000f;
    localparam logic [15:0] SEC_PER_MIN = 16'h003c;
    localparam logic [15:0] MAX_S_SEC = 16'((32'(MAX_S_MIN) * 32'(SEC_PER_MIN)));
    localparam logic [15:0] MAX_T_SEC = 16'((32'(MAX_T_MIN) * 32'(SEC_PER_MIN)));

    // Installation frame period and installation timeout, in seconds.
    localparam logic [15:0] INST_PERIOD_SEC = 16'h000a;
    localparam logic [15:0] INST_TIMEOUT_SEC = 16'h0258;

    // Control codes.
    localparam logic [7:0] C_SND_NR = 8'h44;
    localparam logic [7:0] C_ACC_DMD = 8'h48;
    localparam logic [7:0] C_ACC_NR = 8'h47;
    localparam logic [7:0] C_INST = 8'h46;
    localparam logic [7:0] C_CNF_INST = 8'h06;
    localparam logic [7:0] C_SND_UD_A = 8'h53;
    localparam logic [7:0] C_SND_UD_B = 8'h73;
    localparam logic [7:0] C_REQ1_A = 8'h5a;
    localparam logic [7:0] C_REQ1_B = 8'h7a;
    localparam logic [7:0] C_REQ2_A = 8'h5b;
    localparam logic [7:0] C_REQ2_B = 8'h7b;
    localparam logic [7:0] C_ACK = 8'h00;
    localparam logic [7:0] C_RSP_UD = 8'h08;

    // Application codes.
    localparam logic [7:0] CI_SET_TIME = 8'h6c;
    localparam logic [7:0] CI_ADJ_TIME = 8'h6d;
    localparam logic [7:0] CI_METER = 8'h7a;

    // One-byte control field: four single-bit fields over a function nibble.
    typedef struct packed {
        logic rsvd;
        logic prm;
        logic fcb;
        logic fcv;
        logic [3:0] func;
    } mlmh_ctrl_t;

    // Received frame header.
    typedef struct packed {
        mlmh_ctrl_t c;
        logic [7:0] ci;
    } mlmh_rx_t;

    // Frame header handed to the framer for transmission.
    typedef struct packed {
        mlmh_ctrl_t c;
        logic [7:0] ci;
        logic sync;
        logic [7:0] acc;
        logic [7:0] status;
    } mlmh_tx_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } mlmh_st_t;

    // Whole state of the handler.
    typedef struct packed {
        mlmh_st_t st;
        mlmh_tx_t tx;
        logic per_pend;
        logic inst_pend;
        logic rep_pend;
        mlmh_ctrl_t rep_c;
        logic installing;
        logic [7:0] acc;
        logic [15:0] per_cnt;
        logic [15:0] inst_per;
        logic [15:0] inst_tmo;
        logic time_set;
        logic time_adj;
    } mlmh_state_t;

    // State of the seconds prescaler.
    typedef struct packed {
        logic [26:0] cnt;
        logic tick;
    } mlmh_pre_t;

endpackage : mlmh_pkg

// >>> core/mlmh_prescale.sv
// Prescaler that gives a one-cycle tick every LIMIT clock cycles.
// Assumes LIMIT fits the 27-bit count of the package type.
`timescale 1ns/1ps
`default_nettype none
module mlmh_prescale #(
    parameter int unsigned LIMIT = mlmh_pkg::CYC_PER_SEC
) (
    input wire logic CLK,
    input wire logic SRST,
    output logic TICK
);
    mlmh_pkg::mlmh_pre_t s;
    mlmh_pkg::mlmh_pre_t next_s;

    // Count up and wrap, pulsing the tick on the wrap.
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt >= 27'(LIMIT - 1)) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 27'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign TICK = s.tick;

    a_tick_single: assert property (@(posedge CLK) disable iff (SRST)
        TICK && LIMIT > 1 |=> !TICK) else $error("Prescaler tick lasted two cycles.");

endmodule : mlmh_prescale
`default_nettype wire
